//--- hdl/quad_sub_lane_receiver.v
/*
  Receive side of the four-signal sub-lane gearbox: bit demux, block sync,
  marker lock, parity check, reorder, descramble, deal-out, idle checker,
  idle insert/delete and rescramble per output signal.
  Assumes link pins are sampled by ref_clk at several times the link rate,
  and that config and tick inputs come from logic on ref_clk.
*/
// Summary of operation
// - Physical lanes bit-demultiplexed into four sub-lanes; two-lane or one-lane mode.
// - Optional physical test-pattern detection; not built, so no management variables.
// - Each sub-lane finds 66-bit block lock independently.
// - Each sub-lane locks onto whichever of the four marker values it receives.
// - Markers arrive together on all sub-lanes after every 16383 data blocks.
// - Marker octets per lane, upper three the inverse, sent LSB first.
// - Received marker parity mismatching computed parity bumps that sub-lane's counter.
// - Parity spans previous marker inclusive to current marker exclusive.
// - After marker lock, sub-lanes reorder to the position their marker names.
// - Marker blocks are removed from each sub-lane.
// - Merge one block per sub-lane in turn, sub-lane 0 to 3.
// - One descrambler on the 64 payload bits; sync header passes untouched.
// - Descrambled blocks dealt round-robin; sub-lane n feeds signal n.
// - Optional idle test-pattern checker per output signal, built here.
// - Checker runs only with alignment up and receive test mode on.
// - Each block that is not the all-idle control block adds one error.
// - Idles inserted or deleted per signal to match its output rate.
// - Each output signal may run at its own independent output rate.
// - Each output signal is rescrambled after idle adaptation.
`timescale 1ns/10ps
`default_nettype none
`include "lane_demux_regs.vh"

module quad_sub_lane_receiver #(
  parameter AM_SPACING = `AM_SPACING,
  parameter FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         srst,
  // Physical link pins
  input  wire         link_clk,
  input  wire [1:0]   link_data,
  // Configuration
  input  wire         one_lane_mode,
  input  wire [3:0]   test_mode,
  // Output signal rate ticks
  input  wire [3:0]   out_tick,
  // Output blocks
  output wire [263:0] out_block,
  output wire [3:0]   out_valid,
  // Status
  output wire [3:0]   block_lock,
  output wire [3:0]   am_lock,
  output wire         align_status,
  output wire [63:0]  bip_err_cnt,
  output wire [63:0]  test_err_cnt
);

  localparam integer AM_LAST_I = AM_SPACING - 1;
  localparam [13:0]  AM_LAST   = AM_LAST_I[13:0];

  // =====================================================================
  // Functions
  function [121:0] scr64;
    input [63:0] din;
    input [57:0] st;
    input        desc;
    integer      i;
    reg   [57:0] s;
    reg   [63:0] o;
    begin
      s = st;
      for (i = 0; i < 64; i = i + 1) begin
        o[i] = din[i] ^ s[`SCR_TAP_A] ^ s[`SCR_TAP_B];
        s = {s[56:0], desc ? din[i] : o[i]};
      end
      scr64 = {s, o};
    end
  endfunction

  function [7:0] bip3;
    input [65:0] b;
    integer      k;
    integer      j;
    begin
      bip3 = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        for (j = 0; j < 8; j = j + 1) begin
          bip3[k] = bip3[k] ^ b[2 + k + 8 * j];
        end
      end
      bip3[3] = bip3[3] ^ b[0];
      bip3[4] = bip3[4] ^ b[1];
    end
  endfunction

  function [23:0] mrk_of;
    input [1:0] i;
    begin
      case (i)
        2'h0:    mrk_of = `MRK_LANE0;
        2'h1:    mrk_of = `MRK_LANE1;
        2'h2:    mrk_of = `MRK_LANE2;
        default: mrk_of = `MRK_LANE3;
      endcase
    end
  endfunction

  function [2:0] mrk_hit;
    input [65:0] b;
    integer      k;
    begin
      mrk_hit = 3'h0;
      for (k = 0; k < 4; k = k + 1) begin
        if (b[1:0] == `CTRL_HDR && b[`MRK_LO +: 24] == mrk_of(k[1:0]) &&
            b[`MRK_INV_POS +: 24] == ~mrk_of(k[1:0])) begin
          mrk_hit = {1'b1, k[1:0]};
        end
      end
    end
  endfunction

  // =====================================================================
  // Link sampling; only the data path is watched, no PMA pattern checker
  reg  [2:0] lc_s;
  reg  [1:0] ld_s1;
  reg  [1:0] ld_s2;
  reg  [1:0] ph;
  reg  [3:0] bit_v;
  reg  [3:0] bit_d;
  wire       lc_rise = lc_s[1] & ~lc_s[2];
  integer    m;

  always @(posedge ref_clk) begin
    if (srst) begin
      lc_s  <= 3'h0;
      ld_s1 <= 2'h0;
      ld_s2 <= 2'h0;
      ph    <= 2'h0;
    end else begin
      lc_s  <= {lc_s[1:0], link_clk};
      ld_s1 <= link_data;
      ld_s2 <= ld_s1;
      if (lc_rise) begin
        ph <= one_lane_mode ? ph + 2'h1 : {1'b0, ~ph[0]};
      end
    end
  end

  // Bit demux: one lane rotates over all four, two lanes over a pair each
  always @* begin
    for (m = 0; m < 4; m = m + 1) begin
      bit_v[m] = lc_rise & (one_lane_mode ? (ph == m[1:0]) : (ph[0] == m[0]));
      bit_d[m] = (one_lane_mode || m < 2) ? ld_s2[0] : ld_s2[1];
    end
  end

  // =====================================================================
  // Per sub-lane sync, marker lock and parity
  wire [263:0] lane_hold;
  wire [7:0]   lane_id;
  wire [3:0]   lane_pend;
  wire [3:0]   take;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : sub
      reg  [65:0] sh;
      reg  [6:0]  cnt;
      reg         blk_lk;
      reg  [6:0]  gcnt;
      reg  [4:0]  bcnt;
      reg  [13:0] acnt;
      reg         alk;
      reg         afirst;
      reg  [1:0]  aid;
      reg  [1:0]  abad;
      reg  [7:0]  bip;
      reg  [15:0] berr;
      reg         pend;
      reg  [65:0] hold;
      wire [65:0] nb     = {bit_d[g], sh[65:1]};
      wire        done   = bit_v[g] && cnt == `BIT_LAST;
      wire        hok    = nb[0] ^ nb[1];
      wire [2:0]  mh     = mrk_hit(nb);
      wire        at_exp = acnt == AM_LAST;
      wire        mk_ok  = mh[2] && mh[1:0] == aid;

      always @(posedge ref_clk) begin
        if (srst) begin
          sh     <= 66'h0;
          cnt    <= 7'h00;
          blk_lk <= 1'b0;
          gcnt   <= 7'h00;
          bcnt   <= 5'h00;
          acnt   <= 14'h0000;
          alk    <= 1'b0;
          afirst <= 1'b0;
          aid    <= 2'h0;
          abad   <= 2'h0;
          bip    <= 8'h00;
          berr   <= 16'h0000;
          pend   <= 1'b0;
          hold   <= 66'h0;
        end else begin
          if (bit_v[g]) begin
            sh  <= nb;
            cnt <= done ? 7'h00 : cnt + 7'h01;
          end
          // Slip is one bit: the window simply closes again on the next bit
          if (done && !blk_lk) begin
            if (!hok) begin
              cnt  <= `BIT_LAST;
              gcnt <= 7'h00;
            end else if (gcnt == `SH_GOOD_LAST) begin
              blk_lk <= 1'b1;
              gcnt   <= 7'h00;
              bcnt   <= 5'h00;
            end else begin
              gcnt <= gcnt + 7'h01;
            end
          end else if (done) begin
            gcnt <= gcnt + 7'h01;
            if (!hok && bcnt == `SH_BAD_LAST) begin
              blk_lk <= 1'b0;
              cnt    <= `BIT_LAST;
              gcnt   <= 7'h00;
            end else if (gcnt == `SH_GOOD_LAST) begin
              bcnt <= 5'h00;
            end else if (!hok) begin
              bcnt <= bcnt + 5'h01;
            end
          end
          if (!blk_lk) begin
            alk    <= 1'b0;
            afirst <= 1'b0;
          end else if (done) begin
            bip  <= bip ^ bip3(nb);
            acnt <= at_exp ? 14'h0000 : acnt + 14'h0001;
            if (!alk && (!afirst || at_exp)) begin
              acnt <= 14'h0000;
              bip  <= bip3(nb);
              abad <= 2'h0;
              if (afirst && mk_ok) begin
                alk <= 1'b1;
              end else begin
                afirst <= mh[2];
                aid    <= mh[1:0];
              end
            end else if (alk && at_exp) begin
              bip <= bip3(nb);
              if (mk_ok) begin
                abad <= 2'h0;
                if (nb[`BIP3_POS +: 8] != bip && berr != 16'hFFFF) begin
                  berr <= berr + 16'h0001;
                end
              end else if (abad == `AM_BAD_LAST) begin
                alk    <= 1'b0;
                afirst <= 1'b0;
              end else begin
                abad <= abad + 2'h1;
              end
            end
          end
          // A new block overwrites a held one; set beats the merger's clear
          if (take[g]) begin
            pend <= 1'b0;
          end
          if (done && blk_lk && alk && !at_exp) begin
            pend <= 1'b1;
            hold <= nb;
          end
        end
      end

      assign lane_hold[66*g +: 66] = hold;
      assign lane_id[2*g +: 2]     = aid;
      assign lane_pend[g]          = pend;
      assign block_lock[g]         = blk_lk;
      assign am_lock[g]            = alk;
      assign bip_err_cnt[16*g +: 16] = berr;
    end
  endgenerate

  assign align_status = &am_lock;

  // =====================================================================
  // Reorder, merge and descramble
  // No deskew buffer: lanes must stay within about one block of each other
  reg  [1:0]   mp;
  reg  [57:0]  dst;
  reg  [1:0]   sel;
  reg          found;
  reg          warm;
  wire [3:0]   fifo_rdy;
  integer      n;

  always @* begin
    sel   = 2'h0;
    found = 1'b0;
    for (n = 0; n < 4; n = n + 1) begin
      if (lane_pend[n] && lane_id[2*n +: 2] == mp) begin
        found = 1'b1;
        sel   = n[1:0];
      end
    end
  end

  wire [65:0]  mblk = lane_hold[sel*66 +: 66];
  wire [121:0] desc = scr64(mblk[65:2], dst, 1'b1);
  wire [65:0]  dblk = {desc[63:0], mblk[1:0]};
  wire         push = align_status && found && fifo_rdy[mp];
  // First merged block only primes the descrambler; its payload would be garbage
  wire         load = push && warm;

  generate
    for (g = 0; g < 4; g = g + 1) begin : tk
      assign take[g] = push && sel == g;
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (srst) begin
      mp   <= 2'h0;
      dst  <= 58'h0;
      warm <= 1'b0;
    end else if (!align_status) begin
      mp <= 2'h0;
    end else if (push) begin
      mp   <= mp + 2'h1;
      dst  <= desc[121:64];
      warm <= 1'b1;
    end
  end

  // =====================================================================
  // Per output signal: checker, rate adaptation, rescramble
  generate
    for (g = 0; g < 4; g = g + 1) begin : sig
      wire         fv;
      wire [65:0]  fd;
      wire [4:0]   lv;
      reg  [15:0]  terr;
      reg  [57:0]  ss;
      reg  [65:0]  ob;
      reg          ov;
      wire         is_idle = fd == `IDLE_BLK;
      wire         drop = fv && !out_tick[g] && lv >= `DEL_LEVEL && is_idle;
      wire         pop  = drop || (out_tick[g] && fv);
      wire [65:0]  eb   = fv ? fd : `IDLE_BLK;
      wire [121:0] sc   = scr64(eb[65:2], ss, 1'b0);

      block_fifo #(
        .WIDTH (66),
        .DEPTH (FIFO_DEPTH),
        .AW    (4)
      ) u_fifo (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_valid  (load && mp == g),
        .in_ready  (fifo_rdy[g]),
        .in_data   (dblk),
        .out_valid (fv),
        .out_ready (pop),
        .out_data  (fd),
        .level     (lv)
      );

      // Each tick stands for one block time of that signal's own output clock
      always @(posedge ref_clk) begin
        if (srst) begin
          terr <= 16'h0000;
          ss   <= 58'h0;
          ob   <= 66'h0;
          ov   <= 1'b0;
        end else begin
          if (load && mp == g && test_mode[g] && dblk != `IDLE_BLK &&
              terr != 16'hFFFF) begin
            terr <= terr + 16'h0001;
          end
          ov <= out_tick[g];
          if (out_tick[g]) begin
            ob <= {sc[63:0], eb[1:0]};
            ss <= sc[121:64];
          end
        end
      end

      assign out_block[66*g +: 66]    = ob;
      assign out_valid[g]             = ov;
      assign test_err_cnt[16*g +: 16] = terr;
    end
  endgenerate

endmodule

`default_nettype wire

//--- hdl/lane_demux_regs.vh
/*
  Constants for the quad sub-lane receiver: block layout, marker values,
  lock thresholds and rate-adaptation levels.
  Assumes it is included by bare name from the design files.
*/
`ifndef LANE_DEMUX_REGS_VH
`define LANE_DEMUX_REGS_VH

// =====================================================================
// Block layout
`define BLK_W        66
`define CTRL_HDR     2'h1
`define MRK_LO       2
`define BIP3_POS     26
`define MRK_INV_POS  34
`define IDLE_BLK     66'h0000000000000079

// =====================================================================
// Marker octets M2,M1,M0 per sub-lane; M6..M4 are the inverse
`define MRK_LANE0    24'hAFB480
`define MRK_LANE1    24'h1D8529
`define MRK_LANE2    24'hD82A11
`define MRK_LANE3    24'h4D7EBF

// =====================================================================
// Lock thresholds and timing counts
`define SH_GOOD_LAST 7'h3F
`define SH_BAD_LAST  5'h0F
`define AM_BAD_LAST  2'h3
`define AM_SPACING   16384
`define BIT_LAST     7'h41

// =====================================================================
// Scrambler taps (x^39, x^58) and rate adaptation
`define SCR_TAP_A    38
`define SCR_TAP_B    57
`define DEL_LEVEL    5'h0C
`define FIFO_DEPTH   16

`endif

//--- hdl/block_fifo.v
/*
  Block FIFO: one per output signal, width and depth as parameters.
  Assumes DEPTH is 2**AW and both sides share ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module block_fifo #(
  parameter WIDTH = 66,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             srst,
  // Filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);

  localparam integer DEPTH_I = DEPTH;
  localparam [AW:0]  FULL    = DEPTH_I[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp;
  reg [AW:0]      rp;

  assign level     = wp - rp;
  assign in_ready  = level != FULL;
  assign out_valid = level != {(AW+1){1'b0}};
  assign out_data  = mem[rp[AW-1:0]];

  // =====================================================================
  // Pointers
  always @(posedge ref_clk) begin
    if (srst) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && in_ready) begin
        wp <= wp + {{AW{1'b0}}, 1'b1};
      end
      if (out_valid && out_ready) begin
        rp <= rp + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // =====================================================================
  // Storage
  always @(posedge ref_clk) begin
    if (in_valid && in_ready) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end

endmodule

`default_nettype wire

//--- bench/lane_demux_monitor.sv
/* Checker on the quad sub-lane receiver ports.
   Assumes it is bound to the receiver top; one ref_clk domain. */
`timescale 1ns/10ps
`default_nettype none
module lane_demux_monitor #(
  parameter int AM_SPACING = 16384,
  parameter int FIFO_DEPTH = 16
) (
  // Clock, reset and inputs
  input wire logic         ref_clk,
  input wire logic         srst,
  input wire logic         link_clk,
  input wire logic [1:0]   link_data,
  input wire logic         one_lane_mode,
  input wire logic [3:0]   test_mode,
  input wire logic [3:0]   out_tick,
  // Outputs
  input wire logic [263:0] out_block,
  input wire logic [3:0]   out_valid,
  input wire logic [3:0]   block_lock,
  input wire logic [3:0]   am_lock,
  input wire logic         align_status,
  input wire logic [63:0]  bip_err_cnt,
  input wire logic [63:0]  test_err_cnt
);
  // ====================
  // Helpers: lock cannot beat 64 blocks of two link edges a bit
  localparam int min_lock = 16896;
  int since_rst;
  int since_lock;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  always @(posedge ref_clk) begin
    since_rst  <= srst ? 0 : since_rst + 1;
    since_lock <= (srst || !block_lock[0]) ? 0 : since_lock + 1;
  end
  // ====================
  // Assertions
  a_valid_follows_tick: assert property (
    !$past(srst) |-> out_valid == $past(out_tick))
    else $error("out_valid does not follow out_tick");
  a_align_all_lanes: assert property (align_status == &am_lock)
    else $error("align_status differs from marker locks");
  a_marker_lock_late: assert property (
    $rose(am_lock[0]) |-> block_lock[0] && since_lock >= AM_SPACING * 264)
    else $error("marker lock too soon after block lock");
  for (genvar n = 0; n < 4; n++) begin : g_sig
    a_block_holds: assert property (
      !$past(srst) && !$past(out_tick[n]) |-> $stable(out_block[66*n +: 66]))
      else $error("out_block changed without a tick");
    a_header_valid: assert property (
      out_valid[n] |-> out_block[66*n] != out_block[66*n+1])
      else $error("output sync header invalid");
    a_lock_not_early: assert property ($rose(block_lock[n]) |-> since_rst >= min_lock)
      else $error("block lock too early");
    a_bip_step: assert property (
      !$past(srst) && $changed(bip_err_cnt[16*n +: 16]) |-> $past(am_lock[n])
      && bip_err_cnt[16*n +: 16] == $past(bip_err_cnt[16*n +: 16]) + 16'h1)
      else $error("parity counter moved wrongly");
    a_test_step: assert property (
      !$past(srst) && $changed(test_err_cnt[16*n +: 16]) |->
      ($past(test_mode[n]) || $past(test_mode[n], 2)) && $past(align_status)
      && test_err_cnt[16*n +: 16] == $past(test_err_cnt[16*n +: 16]) + 16'h1)
      else $error("pattern counter moved wrongly");
  end
endmodule
`default_nettype wire

//--- bench/far_end_mux_model.sv
/* Far-end multiplexer model: four scrambled sub-lanes with markers.
   Assumes two-lane mode and the design header on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "lane_demux_regs.vh"
module far_end_mux_model #(
  parameter int AM_SPACING = 16384
) (
  // Link pins
  output var logic       link_clk,
  output var logic [1:0] link_data,
  // Control from the bench
  input  wire logic       start,
  input  wire logic [3:0] data_lanes,
  input  wire logic       bip_flip,
  output var int          marker_count
);
  logic [57:0] scr;
  logic [65:0] blk [4];
  logic [7:0]  bip [4];
  int          nblk;
  // ====================
  // Block builders
  function automatic logic [65:0] marker(input int n, input logic [7:0] b);
    logic [23:0] m;
    m = n == 0 ? `MRK_LANE0 : n == 1 ? `MRK_LANE1 : n == 2 ? `MRK_LANE2 : `MRK_LANE3;
    return {~b, ~m, b, m, 2'h1};
  endfunction
  function automatic logic [65:0] scramble(input logic [65:0] b);
    logic o;
    for (int k = 2; k < 66; k++) begin
      o    = b[k] ^ scr[`SCR_TAP_A] ^ scr[`SCR_TAP_B];
      scr  = {scr[56:0], o};
      b[k] = o;
    end
    return b;
  endfunction
  // ====================
  // Sender: lanes built 0 to 3 so one scrambler runs over the interleave
  initial begin
    link_clk     = 1'b0;
    link_data    = 2'h0;
    marker_count = 0;
    scr          = '0;
    nblk         = 0;
    foreach (bip[n]) bip[n] = '0;
    wait (start);
    forever begin
      for (int n = 0; n < 4; n++) begin
        if (nblk % AM_SPACING == 0) begin
          blk[n] = marker(n, bip[n] ^ {7'h0, bip_flip && n == 0});
          bip[n] = '0;
        end else begin
          blk[n] = scramble(data_lanes[n] ? {8'(n), 48'h0, 8'hD0, 2'h2} : `IDLE_BLK);
        end
        for (int k = 0; k < 66; k++)
          bip[n][k < 2 ? k + 3 : (k - 2) % 8] ^= blk[n][k];
      end
      marker_count += nblk % AM_SPACING == 0;
      nblk++;
      // Lanes cross over so that reorder by marker is really needed
      for (int k = 0; k < 132; k++) begin
        link_data = {blk[1 - k % 2][k / 2], blk[3 - k % 2][k / 2]};
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/quad_sub_lane_receiver_test.sv
/* Bench for the quad sub-lane receiver: lock, parity, stream, pattern checker.
   Assumes the far-end model and the design header on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "lane_demux_regs.vh"
module quad_sub_lane_receiver_test;
  localparam int am_spacing     = 4;
  localparam int tick_period[4] = '{500, 300, 2, 1};
  logic         ref_clk, srst, link_clk, start, flip, align_status;
  logic [1:0]   link_data;
  logic [3:0]   test_mode, out_tick, out_valid, block_lock, am_lock, data_lanes;
  logic [263:0] out_block;
  logic [63:0]  bip_err_cnt, test_err_cnt;
  logic [57:0]  dsc [4];
  int           bad_count, checks, marks, seen1, cyc;
  quad_sub_lane_receiver #(.AM_SPACING(am_spacing)) u_quad_sub_lane_receiver (
    .ref_clk(ref_clk), .srst(srst), .link_clk(link_clk), .link_data(link_data),
    .one_lane_mode(1'b0), .test_mode(test_mode), .out_tick(out_tick),
    .out_block(out_block), .out_valid(out_valid), .block_lock(block_lock),
    .am_lock(am_lock), .align_status(align_status), .bip_err_cnt(bip_err_cnt),
    .test_err_cnt(test_err_cnt));
  far_end_mux_model #(.AM_SPACING(am_spacing)) u_far_end_mux_model (
    .link_clk(link_clk), .link_data(link_data), .start(start),
    .data_lanes(data_lanes), .bip_flip(flip), .marker_count(marks));
  // ====================
  // Compare tasks and closing
  task automatic chk_cnt(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_blk(input string name, input logic [65:0] exp, input logic [65:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ====================
  // Clock, ticks, output watcher (self-synchronising descramble per signal)
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    cyc <= cyc + 1;
    for (int n = 0; n < 4; n++)
      out_tick[n] <= cyc > 8 && cyc % tick_period[n] == 0;
  end
  task automatic watch(input int n);
    logic [65:0] b;
    logic        o;
    b = out_block[66*n +: 66];
    for (int k = 2; k < 66; k++) begin
      o      = b[k] ^ dsc[n][`SCR_TAP_A] ^ dsc[n][`SCR_TAP_B];
      dsc[n] = {dsc[n][56:0], b[k]};
      b[k]   = o;
    end
    if (b !== `IDLE_BLK) begin
      seen1 += n == 1;
      chk_blk("signal block", {8'(n), 48'h0, 8'hD0, 2'h2}, b);
    end
  endtask
  always @(negedge ref_clk)
    for (int n = 0; n < 4; n++)
      if (out_valid[n] === 1'b1)
        watch(n);
  // ====================
  // Scenarios
  task automatic lock_up();
    for (int w = 0; w < 120000 && align_status !== 1'b1; w++)
      @(negedge ref_clk);
    chk_cnt("block lock", 16'hF, {12'h0, block_lock});
    chk_cnt("marker lock", 16'hF, {12'h0, am_lock});
  endtask
  task automatic bip_check();
    int m;
    for (int i = 0; i < 3; i++) begin
      m = marks;
      wait (marks != m);
      flip = i == 0;
    end
    // Lane 0 rides link bit 1; which of its two slots depends on edge phase
    chk_cnt("parity lane0", 16'h1, bip_err_cnt[63:48] + bip_err_cnt[47:32]);
    chk_cnt("parity others", 16'h0, bip_err_cnt[31:16] | bip_err_cnt[15:0]);
  endtask
  task automatic pattern_check();
    logic [15:0] held;
    test_mode = 4'h3;
    repeat (3000) @(negedge ref_clk);
    test_mode = 4'h0;
    repeat (10) @(negedge ref_clk);
    held = test_err_cnt[31:16];
    chk_cnt("idle signal errors", 16'h0, test_err_cnt[15:0]);
    chk_cnt("data signal errors", 16'h1, {15'h0, held != 16'h0});
    chk_cnt("mode off errors", 16'h0, test_err_cnt[63:48] | test_err_cnt[47:32]);
    repeat (3000) @(negedge ref_clk);
    chk_cnt("errors held", held, test_err_cnt[31:16]);
    chk_cnt("data on signal 1", 16'h1, {15'h0, seen1 > 0});
  endtask
  initial begin
    srst       = 1'b1;
    start      = 1'b0;
    flip       = 1'b0;
    test_mode  = 4'h0;
    out_tick   = 4'h0;
    data_lanes = 4'h6;
    cyc        = 0;
    foreach (dsc[n]) dsc[n] = '0;
    repeat (8) @(negedge ref_clk);
    srst  = 1'b0;
    start = 1'b1;
    lock_up();
    bip_check();
    pattern_check();
    end_of_test();
  end
  initial begin
    repeat (150000) @(posedge ref_clk);
    bad_count++;
    end_of_test();
  end
endmodule
bind quad_sub_lane_receiver lane_demux_monitor #(
  .AM_SPACING(AM_SPACING), .FIFO_DEPTH(FIFO_DEPTH)) u_lane_demux_monitor (
  .ref_clk(ref_clk), .srst(srst), .link_clk(link_clk), .link_data(link_data),
  .one_lane_mode(one_lane_mode), .test_mode(test_mode), .out_tick(out_tick),
  .out_block(out_block), .out_valid(out_valid), .block_lock(block_lock),
  .am_lock(am_lock), .align_status(align_status), .bip_err_cnt(bip_err_cnt),
  .test_err_cnt(test_err_cnt));
`default_nettype wire
